/* File: rtl/uart_shadow_data_port.sv */
// Shadow data port of a UART: receive and transmit character queues
// Assumes receivers and transmitter run on clk and hand over whole characters
//
// Functional notes
// - Data alias seven answers at byte address 0x5000104C as a 32-bit word.
// - Low byte read returns serial or infrared received character per mode.
// - FIFOs off: new character overwrites unread byte and flags overrun.
// - FIFOs on: read returns head of receive FIFO.
// - Receive FIFO full: keep entries, drop new character, flag overrun.
// - Low byte write queues character for serial or infrared output.
// - FIFOs off: single write clears holding-empty flag.
// - FIFOs off: further writes before holding-empty overwrite pending character.
// - FIFOs on: writes accepted until sixteen-deep transmit FIFO is full.
// - Writes while transmit FIFO is full are discarded.

`timescale 1ns/100ps
`default_nettype none

module uart_shadow_data_port (
  input wire logic clk,
  input wire logic nrst,
  input wire shadow_port_pkg::apb_req_t apbReq,
  output shadow_port_pkg::apb_rsp_t apbRsp,
  input wire shadow_port_pkg::char_t serialRxChar,
  input wire shadow_port_pkg::char_t irRxChar,
  output shadow_port_pkg::char_t txChar,
  output logic txToIr,
  input wire logic txAccept,
  output logic irq
);
  import shadow_port_pkg::*;

  // ********************
  // State
  // ********************
  // One struct holds every flop of the port
  typedef struct packed {
    // Receive queue
    logic [DEPTH-1:0][7:0] rxMem;
    ptr_t rxRd;
    ptr_t rxWr;
    cnt_t rxCnt;
    // Transmit queue
    logic [DEPTH-1:0][7:0] txMem;
    ptr_t txRd;
    ptr_t txWr;
    cnt_t txCnt;
    // Control and events
    logic fifoEn;
    logic irMode;
    logic [EV_W-1:0] intStat;
    logic [EV_W-1:0] intMask;
    // Transmit output stage
    logic outValid;
    logic [7:0] outData;
    logic outIr;
    // Bus answer and interrupt
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ********************
  // Helpers
  // ********************
  function automatic ptr_t incPtr(input ptr_t p, input logic fifoOn);
    incPtr = fifoOn ? ptr_t'(p + 1'b1) : '0;
  endfunction

  function automatic logic addrIs(input logic [31:0] a, input logic [31:0] target);
    addrIs = (a == target);
  endfunction

  function automatic logic isMapped(input logic [31:0] a);
    isMapped = addrIs(a, DATA_ALIAS_ADDR) || addrIs(a, CTRL_ADDR) ||
      addrIs(a, LINE_STATUS_ADDR) || addrIs(a, INT_STATUS_ADDR) ||
      addrIs(a, INT_MASK_ADDR);
  endfunction

  function automatic cnt_t cntInc(input cnt_t c);
    cntInc = cnt_t'(c + 1'b1);
  endfunction

  function automatic cnt_t cntDec(input cnt_t c);
    cntDec = cnt_t'(c - 1'b1);
  endfunction

  function automatic logic isEmpty(input cnt_t c);
    isEmpty = (c == '0);
  endfunction

  // Line status byte from queue levels
  function automatic logic [7:0] lineView(input cnt_t rxc, input cnt_t txc, input logic busy);
    lineView = '0;
    lineView[LS_DATA_READY_BIT] = ~isEmpty(rxc);
    lineView[LS_HOLD_EMPTY_BIT] = isEmpty(txc);
    lineView[LS_TX_IDLE_BIT] = isEmpty(txc) & ~busy;
  endfunction

  // ********************
  // Working signals
  // ********************
  logic setup;
  logic access;
  logic wrAcc;
  logic rdAcc;
  logic hitData;
  logic hitCtrl;
  logic hitIntStat;
  logic hitIntMask;
  // Events and queue control
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;
  char_t rxIn;
  logic rxPop;
  logic txLoad;
  logic txPush;
  cnt_t limit;
  cnt_t rxLeft;
  cnt_t txLeft;
  logic [7:0] lineStatus;

  // ********************
  // Next state
  // ********************
  always_comb begin
    // Hold unless an event below changes it
    s_nxt = s_r;
    setup = apbReq.psel & ~apbReq.penable;
    access = apbReq.psel & apbReq.penable & s_r.pready;
    wrAcc = access & apbReq.pwrite;
    rdAcc = access & ~apbReq.pwrite;
    hitData = addrIs(apbReq.paddr, DATA_ALIAS_ADDR);
    hitCtrl = addrIs(apbReq.paddr, CTRL_ADDR);
    hitIntStat = addrIs(apbReq.paddr, INT_STATUS_ADDR);
    hitIntMask = addrIs(apbReq.paddr, INT_MASK_ADDR);
    evSet = '0;
    evClr = '0;
    limit = s_r.fifoEn ? DEPTH_CNT : SINGLE_CNT;

    // Receive side
    // Only the receiver of the current mode is heard
    rxIn = s_r.irMode ? irRxChar : serialRxChar;
    rxPop = rdAcc & hitData & ~isEmpty(s_r.rxCnt);
    // Pop frees a slot before the arrival check
    rxLeft = rxPop ? cntDec(s_r.rxCnt) : s_r.rxCnt;
    if (rxPop) begin
      s_nxt.rxRd = incPtr(s_r.rxRd, s_r.fifoEn);
    end
    s_nxt.rxCnt = rxLeft;
    if (rxIn.valid) begin
      if (rxLeft < limit) begin
        s_nxt.rxMem[s_r.rxWr] = rxIn.data;
        s_nxt.rxWr = incPtr(s_r.rxWr, s_r.fifoEn);
        s_nxt.rxCnt = cntInc(rxLeft);
        evSet[EV_RX] = 1'b1;
      end else if (!s_r.fifoEn) begin
        // Single holding byte lost to the newcomer
        s_nxt.rxMem[s_r.rxRd] = rxIn.data;
        evSet[EV_RX] = 1'b1;
        evSet[EV_OVERRUN] = 1'b1;
      end else begin
        evSet[EV_OVERRUN] = 1'b1;
      end
    end

    // Transmit side, output stage is one slot beyond the queue
    txLoad = (~s_r.outValid | txAccept) & ~isEmpty(s_r.txCnt);
    if (s_r.outValid & txAccept) begin
      s_nxt.outValid = 1'b0;
    end
    if (txLoad) begin
      s_nxt.outValid = 1'b1;
      s_nxt.outData = s_r.txMem[s_r.txRd];
      // Mode sampled at load time
      s_nxt.outIr = s_r.irMode;
      s_nxt.txRd = incPtr(s_r.txRd, s_r.fifoEn);
    end
    // Load frees a slot in the same cycle
    txLeft = txLoad ? cntDec(s_r.txCnt) : s_r.txCnt;
    s_nxt.txCnt = txLeft;
    txPush = wrAcc & hitData;
    if (txPush) begin
      if (txLeft < limit) begin
        // Clears the holding-empty flag
        s_nxt.txMem[s_r.txWr] = apbReq.pwdata[7:0];
        s_nxt.txWr = incPtr(s_r.txWr, s_r.fifoEn);
        s_nxt.txCnt = cntInc(txLeft);
      end else if (!s_r.fifoEn) begin
        s_nxt.txMem[s_r.txRd] = apbReq.pwdata[7:0];
      end else begin
        evSet[EV_TX_DROP] = 1'b1;
      end
    end
    // Event on the emptying edge only
    if (!isEmpty(s_r.txCnt) && isEmpty(s_nxt.txCnt)) begin
      evSet[EV_TX_EMPTY] = 1'b1;
    end

    // Control writes
    // Mode bits take effect from the next cycle
    if (wrAcc && hitCtrl) begin
      s_nxt.fifoEn = apbReq.pwdata[CTRL_FIFO_EN_BIT];
      s_nxt.irMode = apbReq.pwdata[CTRL_IR_MODE_BIT];
      if (apbReq.pwdata[CTRL_FIFO_EN_BIT] != s_r.fifoEn) begin
        // FIFO enable change flushes both queues; an infrared mode change alone does not
        s_nxt.rxRd = '0;
        s_nxt.rxWr = '0;
        s_nxt.rxCnt = '0;
        s_nxt.txRd = '0;
        s_nxt.txWr = '0;
        s_nxt.txCnt = '0;
      end
    end
    if (wrAcc && hitIntMask) begin
      s_nxt.intMask = apbReq.pwdata[EV_W-1:0];
    end
    if (wrAcc && hitIntStat) begin
      evClr = apbReq.pwdata[EV_W-1:0];
    end

    // Sticky events, set beats clear
    s_nxt.intStat = (s_r.intStat & ~evClr) | evSet;
    // Level from the next status, so irq stays a flop
    s_nxt.irq = |(s_nxt.intStat & s_nxt.intMask);

    // Line status view
    lineStatus = lineView(s_r.rxCnt, s_r.txCnt, s_r.outValid);

    // APB answer, one wait-free access phase
    // Read data taken at setup; the pop lands at the access edge
    s_nxt.pready = setup;
    // Unmapped address: error with zero data, no effect
    s_nxt.pslverr = setup & ~isMapped(apbReq.paddr);
    if (setup) begin
      s_nxt.prdata = '0;
      case (apbReq.paddr)
        DATA_ALIAS_ADDR: begin
          // Upper bits stay zero
          s_nxt.prdata[7:0] = s_r.rxMem[s_r.rxRd];
        end
        CTRL_ADDR: begin
          s_nxt.prdata[CTRL_FIFO_EN_BIT] = s_r.fifoEn;
          s_nxt.prdata[CTRL_IR_MODE_BIT] = s_r.irMode;
        end
        LINE_STATUS_ADDR: begin
          s_nxt.prdata[7:0] = lineStatus;
        end
        INT_STATUS_ADDR: begin
          s_nxt.prdata[EV_W-1:0] = s_r.intStat;
        end
        INT_MASK_ADDR: begin
          s_nxt.prdata[EV_W-1:0] = s_r.intMask;
        end
        default: begin
          s_nxt.prdata = '0;
        end
      endcase
    end
  end

  // ********************
  // Registers
  // ********************
  // Every flop of the port in one process
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Named reset values over an all-zero base
      s_r <= '0;
      s_r.fifoEn <= CTRL_FIFO_EN_RST;
      s_r.irMode <= CTRL_IR_MODE_RST;
      s_r.intMask <= INT_MASK_RST;
      s_r.outData <= DATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************
  // Outputs
  // ********************
  // Whole-struct drives, one driver per output
  assign apbRsp = '{
    prdata: s_r.prdata,
    pready: s_r.pready,
    pslverr: s_r.pslverr
  };
  assign txChar = '{
    valid: s_r.outValid,
    data: s_r.outData
  };
  assign txToIr = s_r.outIr;
  assign irq = s_r.irq;

endmodule

`default_nettype wire

/* File: rtl/shadow_port_pkg.sv */
// Constants and carrier types of the shadow data port
// Assumes a 20 MHz clock and an APB master with 32-bit data

package shadow_port_pkg;

  // ********************
  // Sizes
  // ********************
  localparam int DEPTH = 16;
  localparam int PW = 4;
  localparam int CW = 5;
  localparam logic [CW-1:0] DEPTH_CNT = 5'h10;
  localparam logic [CW-1:0] SINGLE_CNT = 5'h01;

  // ********************
  // Byte addresses
  // ********************
  localparam logic [31:0] DATA_ALIAS_ADDR = 32'h5000104C;
  localparam logic [31:0] CTRL_ADDR = 32'h50001100;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001104;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h50001108;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000110C;

  // ********************
  // Field positions
  // ********************
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;
  localparam int LS_DATA_READY_BIT = 0;
  localparam int LS_HOLD_EMPTY_BIT = 5;
  localparam int LS_TX_IDLE_BIT = 6;
  localparam int EV_RX = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_TX_DROP = 2;
  localparam int EV_TX_EMPTY = 3;
  localparam int EV_W = 4;

  // ********************
  // Reset values
  // ********************
  localparam logic CTRL_FIFO_EN_RST = 1'b0;
  localparam logic CTRL_IR_MODE_RST = 1'b0;
  localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ********************
  // Carriers
  // ********************
  typedef logic [PW-1:0] ptr_t;
  typedef logic [CW-1:0] cnt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_t;

endpackage

/* File: verif/serial_peer.sv */
// Far-side model: transmitter sink and both character receivers
// Assumes the port's clk and its txChar/txAccept handshake
`timescale 1ns/100ps
`default_nettype none
module serial_peer
  import shadow_port_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire char_t txChar,
  output logic txAccept,
  output char_t serialRxChar,
  output char_t irRxChar
);
  // ********************
  // Sink and sources
  // ********************
  logic [7:0] got[$];
  initial begin
    serialRxChar = '0;
    irRxChar = '0;
  end
  assign txAccept = !stall;
  always @(posedge clk) begin
    if (txChar.valid && txAccept) got.push_back(txChar.data);
  end
  // One-cycle pulse, data inverted once released
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge clk);
    if (ir) irRxChar <= {1'b1, d};
    else serialRxChar <= {1'b1, d};
    @(posedge clk);
    irRxChar <= {1'b0, ~d};
    serialRxChar <= {1'b0, ~d};
  endtask
endmodule
`default_nettype wire

/* File: verif/shadow_port_checker_sva.sv */
// Checker of the shadow data port's bus and transmit handshake
// Assumes binding to the port's top module
`timescale 1ns/100ps
`default_nettype none
module shadow_port_checker
  import shadow_port_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire apb_req_t apbReq,
  input wire apb_rsp_t apbRsp,
  input wire char_t txChar,
  input wire logic txToIr,
  input wire logic txAccept
);
  // ********************
  // Properties
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic hit;
  assign hit = apbRsp.pready && apbReq.paddr == DATA_ALIAS_ADDR;
  ready_follows_setup_a:
    assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready) else $error("late ready");
  ready_single_a:
    assert property (apbRsp.pready |=> !apbRsp.pready) else $error("ready too long");
  ready_in_access_a:
    assert property (apbRsp.pready |-> $past(apbReq.psel && !apbReq.penable))
    else $error("stray ready");
  err_reads_zero_a:
    assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0)
    else $error("bad error reply");
  alias_no_error_a:
    assert property (hit |-> !apbRsp.pslverr) else $error("alias refused");
  upper_byte_zero_a:
    assert property (hit && !apbReq.pwrite |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("upper bits set");
  tx_char_holds_a:
    assert property (txChar.valid && !txAccept |=> txChar.valid && $stable({txChar, txToIr}))
    else $error("char dropped");
  tx_launch_a:
    assert property (hit && apbReq.pwrite && !txChar.valid |-> ##[1:2] txChar.valid)
    else $error("char not offered");
endmodule
bind uart_shadow_data_port shadow_port_checker chk(.clk, .nrst, .apbReq, .apbRsp, .txChar,
  .txToIr, .txAccept);
`default_nettype wire

/* File: verif/uart_shadow_data_port_test.sv */
// Testbench of the shadow data port
// Assumes the serial peer model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module uart_shadow_data_port_test;
  import shadow_port_pkg::*;
  // ********************
  // Bench
  // ********************
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, nrst, stall, txToIr, txAccept, irq, err;
  apb_req_t req;
  apb_rsp_t rsp;
  char_t sRx, iRx, txChar;
  logic [31:0] rdat;
  int n_errors, n_compared, cyc;
  uart_shadow_data_port dut(.clk, .nrst, .apbReq(req), .apbRsp(rsp), .serialRxChar(sRx),
    .irRxChar(iRx), .txChar, .txToIr, .txAccept, .irq);
  serial_peer peer(.clk, .stall, .txChar, .txAccept, .serialRxChar(sRx), .irRxChar(iRx));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, m, e);
    xfer(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic t_reset();
    rd(CTRL_ADDR, ALL, 32'h0);
    rd(INT_MASK_ADDR, ALL, 32'h0);
    rd(LINE_STATUS_ADDR, ALL, 32'h60);
    rd(DATA_ALIAS_ADDR, ALL, 32'h0);
    rd(32'h50001110, ALL, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_tx_single();
    stall <= 1'b1;
    xfer(1'b1, DATA_ALIAS_ADDR, 32'hABCD0141);
    xfer(1'b1, DATA_ALIAS_ADDR, 32'h42);
    xfer(1'b1, DATA_ALIAS_ADDR, 32'h43);
    rd(LINE_STATUS_ADDR, 32'h61, 32'h0);
    chk(txChar.data, 32'h41);
    chk(txToIr, 32'h0);
    stall <= 1'b0;
    repeat (6) @(posedge clk);
    chk(peer.got.size(), 32'h2);
    chk(peer.got[1], 32'h43);
  endtask
  task automatic t_tx_fifo();
    xfer(1'b1, CTRL_ADDR, 32'h1);
    xfer(1'b1, INT_STATUS_ADDR, 32'hF);
    stall <= 1'b1;
    for (int i = 0; i < 18; i++) xfer(1'b1, DATA_ALIAS_ADDR, i);
    rd(INT_STATUS_ADDR, 32'h4, 32'h4);
    peer.got.delete();
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    chk(peer.got.size(), 32'h11);
    chk(peer.got[16], 32'h10);
  endtask
  task automatic t_rx_single();
    xfer(1'b1, CTRL_ADDR, 32'h0);
    xfer(1'b1, INT_STATUS_ADDR, 32'hF);
    xfer(1'b1, INT_MASK_ADDR, 32'h2);
    peer.send(1'b0, 8'hA1);
    peer.send(1'b0, 8'hA2);
    rd(LINE_STATUS_ADDR, 32'h1, 32'h1);
    chk(irq, 32'h1);
    rd(DATA_ALIAS_ADDR, ALL, 32'hA2);
    xfer(1'b1, INT_STATUS_ADDR, 32'h2);
    @(posedge clk);
    chk(irq, 32'h0);
    xfer(1'b1, CTRL_ADDR, 32'h2);
    stall <= 1'b1;
    xfer(1'b1, DATA_ALIAS_ADDR, 32'h5B);
    @(posedge clk);
    chk(txToIr, 32'h1);
    chk(txChar.data, 32'h5B);
    stall <= 1'b0;
    peer.send(1'b1, 8'h5A);
    peer.send(1'b0, 8'h77);
    rd(DATA_ALIAS_ADDR, ALL, 32'h5A);
  endtask
  task automatic t_rx_fifo();
    xfer(1'b1, CTRL_ADDR, 32'h1);
    for (int i = 0; i < 17; i++) peer.send(1'b0, 8'(8'h80 + i));
    for (int i = 0; i < 16; i++) rd(DATA_ALIAS_ADDR, ALL, 32'h80 + i);
    rd(LINE_STATUS_ADDR, 32'h1, 32'h0);
    rd(INT_STATUS_ADDR, 32'h2, 32'h2);
  endtask
  initial begin
    nrst = 1'b0;
    stall = 1'b0;
    req = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx_single();
    t_tx_fifo();
    t_rx_single();
    t_rx_fifo();
    test_done();
  end
endmodule
`default_nettype wire
